// *** rtl/gotb_pkg.sv ***
package gotb_pkg;

  localparam int DATA_W = 32;
  localparam int CUR_W  = 16;
  localparam int TIME_W = 20;

  // Register byte offsets.
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_RATIO_THR = 12'h004;
  localparam logic [11:0] ADDR_NOMINAL   = 12'h008;
  localparam logic [11:0] ADDR_STATUS    = 12'h00c;
  localparam logic [11:0] ADDR_TIMER     = 12'h010;
  localparam logic [11:0] ADDR_SET_BASE  = 12'h040;
  localparam logic [11:0] SET_STRIDE     = 12'h020;
  localparam logic [11:0] SET_SPAN       = 12'h080;
  localparam logic [2:0]  SREG_PICKUP    = 3'h0;
  localparam logic [2:0]  SREG_FIXED     = 3'h1;
  localparam logic [2:0]  SREG_MULT      = 3'h2;
  localparam logic [2:0]  SREG_RESET     = 3'h3;
  localparam logic [2:0]  SREG_MIN       = 3'h4;
  localparam logic [2:0]  SREG_CFG       = 3'h5;

  // Timing constants in their own units.
  localparam int CLK_HZ         = 20000000;
  localparam int MS_PER_S       = 1000;
  localparam int TICK_MS        = 1;
  localparam int TICK_CYCLES    = CLK_HZ / MS_PER_S * TICK_MS;
  localparam logic [TIME_W-1:0] LOG_MIN_MS = 20'h00014;

  // Multiples of pickup and nominal current for the largest current, and the percent scale of the inrush ratio.
  localparam int PICKUP_MAX_MULT = 20;
  localparam int CALC_NOM_MULT   = 40;
  localparam int MEAS_NOM_MULT   = 25;
  localparam int SENS_NOM_MULT_X2 = 5;
  localparam int RATIO_PCT       = 100;

  typedef enum logic [3:0] {
    CURVE_FIXED, CURVE_IEC_NORMAL, CURVE_IEC_VERY, CURVE_IEC_LONG, CURVE_IEC_EXTREME,
    CURVE_IEEE_MODERATE, CURVE_IEEE_VERY, CURVE_IEEE_EXTREME, CURVE_R_INVERSE,
    CURVE_LOG, CURVE_THERM_FLAT, CURVE_THERM_IT, CURVE_THERM_I2T, CURVE_THERM_I4T
  } gotb_curve_type;

  typedef enum logic [1:0] {RST_INSTANT, RST_FIXED, RST_CURVE} gotb_rstmode_type;
  typedef enum logic [1:0] {DIR_NONE, DIR_FORWARD, DIR_REVERSE} gotb_dirmode_type;
  typedef enum logic [1:0] {SRC_COMPUTED, SRC_SENSED, SRC_SENSITIVE} gotb_src_type;

  typedef struct packed {
    logic [CUR_W-1:0]  pickup;
    logic [TIME_W-1:0] fixed_delay;
    logic [CUR_W-1:0]  mult;
    logic [TIME_W-1:0] reset_delay;
    logic [TIME_W-1:0] min_delay;
    gotb_curve_type    curve;
    gotb_rstmode_type  reset_mode;
    logic              use_rms;
    gotb_src_type      src;
  } gotb_set_type;

  typedef struct packed {
    logic [CUR_W-1:0] computed_fund;
    logic [CUR_W-1:0] computed_rms;
    logic [CUR_W-1:0] sensed_fund;
    logic [CUR_W-1:0] sensed_rms;
    logic [CUR_W-1:0] sensitive_fund;
    logic [CUR_W-1:0] sensitive_rms;
  } gotb_ground_type;

  typedef struct packed {
    logic [2:0][CUR_W-1:0] fund;
    logic [2:0][CUR_W-1:0] second;
  } gotb_harm_type;

  // Direction indications indexed by [voltage measured][source of the active set is not computed].
  typedef struct packed {
    logic [1:0][1:0] fwd;
    logic [1:0][1:0] rev;
  } gotb_dir_type;

  typedef struct packed {
    gotb_curve_type    curve;
    logic [CUR_W-1:0]  mult;
    logic [CUR_W-1:0]  current;
    logic [CUR_W-1:0]  pickup;
    logic [CUR_W+7:0]  imax;
    gotb_rstmode_type  reset_mode;
  } gotb_curve_req_type;

  typedef struct packed {
    logic [TIME_W-1:0] trip_ms;
    logic [TIME_W-1:0] reset_ms;
    logic [TIME_W-1:0] min_ms;
  } gotb_curve_ans_type;

endpackage

// *** rtl/gotb_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module gotb_timer
  import gotb_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Evaluation inputs.
  input  wire logic              strobe,
  input  wire logic [TIME_W-1:0] elapsed,
  input  wire logic              above,
  input  wire logic [TIME_W-1:0] trip_delay,
  input  wire logic              instant_reset,
  input  wire logic [TIME_W-1:0] reset_delay,
  // Results.
  output logic                   tripped,
  output logic [TIME_W-1:0]      acc_time
);

  typedef struct packed {
    logic [TIME_W-1:0] acc;
    logic [TIME_W-1:0] rst_acc;
    logic              trip;
  } gotb_tstate_type;

  gotb_tstate_type s_r;
  gotb_tstate_type s_nxt;

  function automatic logic [TIME_W-1:0] sat_add(input logic [TIME_W-1:0] a,
                                                input logic [TIME_W-1:0] b);
    logic [TIME_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    return sum[TIME_W] ? {TIME_W{1'b1}} : sum[TIME_W-1:0];
  endfunction

  always_comb begin
    s_nxt = s_r;
    if (strobe) begin
      if (above) begin
        s_nxt.acc     = sat_add(s_r.acc, elapsed);
        s_nxt.rst_acc = '0;
        s_nxt.trip    = sat_add(s_r.acc, elapsed) >= trip_delay;
      end else begin
        s_nxt.trip = 1'b0;
        if (instant_reset) begin
          s_nxt.acc     = '0;
          s_nxt.rst_acc = '0;
        end else if (sat_add(s_r.rst_acc, elapsed) >= reset_delay) begin
          s_nxt.acc     = '0;
          s_nxt.rst_acc = '0;
        end else begin
          s_nxt.rst_acc = sat_add(s_r.rst_acc, elapsed);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign tripped  = s_r.trip;
  assign acc_time = s_r.acc;

endmodule
`default_nettype wire

// *** rtl/gotb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module gotb_top
  import gotb_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock, reset and enable.
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  input  wire logic                CE,
  // APB slave.
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [11:0]         PADDR,
  input  wire logic [DATA_W-1:0]   PWDATA,
  output logic [DATA_W-1:0]        PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // Measurement front end.
  input  wire logic                MEAS_STROBE,
  input  wire gotb_ground_type     GROUND_MEAS,
  input  wire gotb_harm_type       HARM_MEAS,
  input  wire gotb_dir_type        DIR_MEAS,
  // Curve evaluator.
  output gotb_curve_req_type       CURVE_REQ,
  input  wire gotb_curve_ans_type  CURVE_ANS,
  // Protection outputs.
  output logic [2:0]               PHASE_INRUSH_BLOCK,
  output logic                     COMMON_INRUSH_BLOCK,
  output logic                     STAGE_PICKUP,
  output logic                     STAGE_TRIP
);

  typedef struct packed {
    logic [DATA_W-1:0]  prdata;
    logic               pready;
    logic               pslverr;
    gotb_dirmode_type   dir_mode;
    logic               neutral_side;
    logic               volt_measured;
    logic               cur_measured;
    logic               inrush_use;
    logic               per_phase_mode;
    logic [1:0]         active_set;
    logic [7:0]         ratio_thr;
    logic [CUR_W-1:0]   nominal;
    logic [31:0]        presc;
    logic [TIME_W-1:0]  elapsed;
    logic               eval;
    logic [TIME_W-1:0]  eval_elapsed;
    logic               above;
    logic [2:0]         ph_block;
    logic               com_block;
    logic               pickup;
    logic               trip;
    gotb_curve_req_type creq;
  } gotb_state_type;

  gotb_state_type s_r;
  gotb_state_type s_nxt;
  gotb_set_type   sets_r   [4];
  gotb_set_type   sets_nxt [4];
  gotb_set_type   act;

  logic              t_trip;
  logic [TIME_W-1:0] t_acc;
  logic [TIME_W-1:0] trip_delay;
  logic [TIME_W-1:0] reset_delay;
  logic              instant_reset;

  function automatic logic [TIME_W-1:0] tmax(input logic [TIME_W-1:0] a,
                                             input logic [TIME_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic is_thermal(input gotb_curve_type c);
    return (c == CURVE_THERM_FLAT) || (c == CURVE_THERM_IT) ||
           (c == CURVE_THERM_I2T) || (c == CURVE_THERM_I4T);
  endfunction

  function automatic logic [DATA_W-1:0] set_read(input gotb_set_type st,
                                                 input logic [2:0] idx);
    logic [DATA_W-1:0] d;
    d = '0;
    unique case (idx)
      SREG_PICKUP: d[CUR_W-1:0]  = st.pickup;
      SREG_FIXED:  d[TIME_W-1:0] = st.fixed_delay;
      SREG_MULT:   d[CUR_W-1:0]  = st.mult;
      SREG_RESET:  d[TIME_W-1:0] = st.reset_delay;
      SREG_MIN:    d[TIME_W-1:0] = st.min_delay;
      SREG_CFG:    d[10:0]       = {st.src, st.use_rms, st.reset_mode, 2'h0, st.curve};
      default:     d             = '0;
    endcase
    return d;
  endfunction

  // Selected quantity: source, then fundamental or RMS.
  function automatic logic [CUR_W-1:0] sel_current(input gotb_ground_type g,
                                                   input gotb_set_type st);
    logic [CUR_W-1:0] v;
    v = '0;
    unique case (st.src)
      SRC_COMPUTED:  v = st.use_rms ? g.computed_rms  : g.computed_fund;
      SRC_SENSED:    v = st.use_rms ? g.sensed_rms    : g.sensed_fund;
      SRC_SENSITIVE: v = st.use_rms ? g.sensitive_rms : g.sensitive_fund;
      default:       v = '0;
    endcase
    return v;
  endfunction

  assign act = sets_r[s_r.active_set];

  // Effective delays from the curve answer to the registered request.
  always_comb begin
    trip_delay    = CURVE_ANS.trip_ms;
    reset_delay   = act.reset_delay;
    instant_reset = (act.reset_mode == RST_INSTANT);
    if (act.curve == CURVE_FIXED) begin
      trip_delay    = act.fixed_delay;
      instant_reset = 1'b1;
    end else if (!is_thermal(act.curve)) begin
      trip_delay = tmax(trip_delay, act.min_delay);
      if (act.curve == CURVE_LOG) begin
        trip_delay = tmax(trip_delay, LOG_MIN_MS);
      end else begin
        trip_delay = tmax(trip_delay, CURVE_ANS.min_ms);
      end
    end
    if (act.reset_mode == RST_CURVE && act.curve != CURVE_LOG) begin
      reset_delay = CURVE_ANS.reset_ms;
    end
  end

  always_comb begin
    logic [11:0]       off;
    logic [1:0]        sidx;
    logic [2:0]        ridx;
    logic              in_set;
    logic              hit;
    logic [CUR_W-1:0]  cur;
    logic              dir_fwd;
    logic              dir_rev;
    logic              dir_ok;
    logic              blocked;
    logic [CUR_W+7:0]  lim_pick;
    logic [CUR_W+7:0]  lim_nom;
    logic [CUR_W+15:0] h2s;
    logic [CUR_W+15:0] h1s;
    logic [2:0]        hb;
    s_nxt    = s_r;
    sets_nxt = sets_r;
    off      = PADDR - ADDR_SET_BASE;
    sidx     = off[6:5];
    ridx     = off[4:2];
    in_set   = (PADDR >= ADDR_SET_BASE) && (PADDR < ADDR_SET_BASE + SET_SPAN) &&
               (ridx <= SREG_CFG) && (PADDR[1:0] == 2'h0);
    hit      = in_set || (PADDR == ADDR_CTRL) || (PADDR == ADDR_RATIO_THR) ||
               (PADDR == ADDR_NOMINAL) || (PADDR == ADDR_STATUS) || (PADDR == ADDR_TIMER);
    cur      = sel_current(GROUND_MEAS, act);
    dir_fwd  = DIR_MEAS.fwd[s_r.volt_measured][act.src != SRC_COMPUTED];
    dir_rev  = DIR_MEAS.rev[s_r.volt_measured][act.src != SRC_COMPUTED];
    lim_pick = '0;
    lim_nom  = '0;
    h2s      = '0;
    h1s      = '0;
    hb       = '0;
    dir_ok   = 1'b1;
    blocked  = 1'b0;

    // Bus: setup cycle prepares the answer, access cycle completes it.
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !hit;
      s_nxt.prdata  = '0;
      if (!PWRITE && in_set) begin
        s_nxt.prdata = set_read(sets_r[sidx], ridx);
      end else if (!PWRITE) begin
        unique case (PADDR)
          ADDR_CTRL:      s_nxt.prdata[9:0] = {s_r.active_set, s_r.per_phase_mode,
                                               s_r.inrush_use, s_r.cur_measured,
                                               s_r.volt_measured, s_r.neutral_side,
                                               1'b0, s_r.dir_mode};
          ADDR_RATIO_THR: s_nxt.prdata[7:0] = s_r.ratio_thr;
          ADDR_NOMINAL:   s_nxt.prdata[CUR_W-1:0] = s_r.nominal;
          ADDR_STATUS:    s_nxt.prdata[5:0] = {s_r.com_block, s_r.ph_block,
                                               s_r.trip, s_r.pickup};
          ADDR_TIMER:     s_nxt.prdata[TIME_W-1:0] = t_acc;
          default:        s_nxt.prdata = '0;
        endcase
      end
    end
    if (PSEL && PENABLE && s_r.pready && PWRITE && !s_r.pslverr) begin
      if (in_set) begin
        unique case (ridx)
          SREG_PICKUP: sets_nxt[sidx].pickup      = PWDATA[CUR_W-1:0];
          SREG_FIXED:  sets_nxt[sidx].fixed_delay = PWDATA[TIME_W-1:0];
          SREG_MULT:   sets_nxt[sidx].mult        = PWDATA[CUR_W-1:0];
          SREG_RESET:  sets_nxt[sidx].reset_delay = PWDATA[TIME_W-1:0];
          SREG_MIN:    sets_nxt[sidx].min_delay   = PWDATA[TIME_W-1:0];
          SREG_CFG: begin
            sets_nxt[sidx].curve      = gotb_curve_type'(PWDATA[3:0]);
            sets_nxt[sidx].reset_mode = gotb_rstmode_type'(PWDATA[7:6]);
            sets_nxt[sidx].use_rms    = PWDATA[8];
            sets_nxt[sidx].src        = gotb_src_type'(PWDATA[10:9]);
          end
          default: ;
        endcase
      end else begin
        unique case (PADDR)
          ADDR_CTRL: begin
            s_nxt.dir_mode       = gotb_dirmode_type'(PWDATA[1:0]);
            s_nxt.neutral_side   = PWDATA[3];
            s_nxt.volt_measured  = PWDATA[4];
            s_nxt.cur_measured   = PWDATA[5];
            s_nxt.inrush_use     = PWDATA[6];
            s_nxt.per_phase_mode = PWDATA[7];
            s_nxt.active_set     = PWDATA[9:8];
          end
          ADDR_RATIO_THR: s_nxt.ratio_thr = PWDATA[7:0];
          ADDR_NOMINAL:   s_nxt.nominal   = PWDATA[CUR_W-1:0];
          default: ;
        endcase
      end
    end

    // Millisecond base and elapsed time since the previous strobe.
    s_nxt.eval = 1'b0;
    if (s_r.presc == 32'(TICK_CYC - 1)) begin
      s_nxt.presc   = '0;
      s_nxt.elapsed = (s_r.elapsed == {TIME_W{1'b1}}) ? s_r.elapsed
                                                      : s_r.elapsed + 20'h00001;
    end else begin
      s_nxt.presc = s_r.presc + 32'h1;
    end

    // Inrush element.
    for (int p = 0; p < 3; p++) begin
      h2s   = (CUR_W+16)'(HARM_MEAS.second[p]) * (CUR_W+16)'(RATIO_PCT);
      h1s   = (CUR_W+16)'(HARM_MEAS.fund[p]) * (CUR_W+16)'(s_r.ratio_thr);
      hb[p] = s_r.inrush_use && (h2s > h1s);
    end

    // Direction qualification.
    dir_ok = 1'b1;
    if (s_r.dir_mode != DIR_NONE) begin
      dir_ok = s_r.neutral_side &&
               ((s_r.dir_mode == DIR_FORWARD) ? dir_fwd : dir_rev);
    end

    if (MEAS_STROBE) begin
      if (s_r.per_phase_mode) begin
        s_nxt.ph_block  = hb;
        s_nxt.com_block = 1'b0;
      end else begin
        s_nxt.ph_block  = '0;
        s_nxt.com_block = |hb;
      end
      blocked            = s_r.per_phase_mode ? (|hb) : (|hb);
      s_nxt.above        = (cur > act.pickup) && dir_ok && !blocked;
      s_nxt.eval         = 1'b1;
      s_nxt.eval_elapsed = s_r.elapsed;
      // A tick that lands on the strobe edge opens the next interval, so it is not lost.
      s_nxt.elapsed      = (s_r.presc == 32'(TICK_CYC - 1)) ? 20'h00001 : '0;
      lim_pick           = (CUR_W+8)'(act.pickup) * (CUR_W+8)'(PICKUP_MAX_MULT);
      unique case (act.src)
        SRC_COMPUTED:  lim_nom = (CUR_W+8)'(s_r.nominal) * (CUR_W+8)'(CALC_NOM_MULT);
        SRC_SENSED:    lim_nom = (CUR_W+8)'(s_r.nominal) * (CUR_W+8)'(MEAS_NOM_MULT);
        SRC_SENSITIVE: lim_nom = ((CUR_W+8)'(s_r.nominal) *
                                  (CUR_W+8)'(SENS_NOM_MULT_X2)) >> 1;
        default:       lim_nom = '0;
      endcase
      s_nxt.creq.imax       = (lim_pick < lim_nom) ? lim_pick : lim_nom;
      s_nxt.creq.curve      = act.curve;
      s_nxt.creq.mult       = act.mult;
      s_nxt.creq.current    = cur;
      s_nxt.creq.pickup     = act.pickup;
      s_nxt.creq.reset_mode = act.reset_mode;
    end
    s_nxt.pickup = s_r.above;
    s_nxt.trip   = t_trip;
  end

  gotb_timer u_timer (
    .clk           (CLK_SYS),
    .rst           (RST),
    .ce            (CE),
    .strobe        (s_r.eval),
    .elapsed       (s_r.eval_elapsed),
    .above         (s_r.above),
    .trip_delay    (trip_delay),
    .instant_reset (instant_reset),
    .reset_delay   (reset_delay),
    .tripped       (t_trip),
    .acc_time      (t_acc)
  );

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_r <= '0;
      for (int i = 0; i < 4; i++) begin
        sets_r[i] <= '0;
      end
    end else if (CE) begin
      s_r    <= s_nxt;
      sets_r <= sets_nxt;
    end
  end

  assign PRDATA              = s_r.prdata;
  assign PREADY              = s_r.pready;
  assign PSLVERR             = s_r.pslverr;
  assign CURVE_REQ           = s_r.creq;
  assign PHASE_INRUSH_BLOCK  = s_r.ph_block;
  assign COMMON_INRUSH_BLOCK = s_r.com_block;
  assign STAGE_PICKUP        = s_r.pickup;
  assign STAGE_TRIP          = s_r.trip;

endmodule
`default_nettype wire

// *** sim/gotb_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module gotb_mon
  import gotb_pkg::*;
(
  // Clock and control.
  input wire logic               CLK_SYS,
  input wire logic               RST,
  input wire logic               CE,
  // Bus handshake.
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  // Measurement and results.
  input wire logic               MEAS_STROBE,
  input wire gotb_curve_req_type CURVE_REQ,
  input wire logic [2:0]         PHASE_INRUSH_BLOCK,
  input wire logic               COMMON_INRUSH_BLOCK,
  input wire logic               STAGE_PICKUP,
  input wire logic               STAGE_TRIP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_ready_after_setup: assert property (PSEL && !PENABLE && CE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_pickup_timing: assert property (!$stable(STAGE_PICKUP) |-> $past(MEAS_STROBE, 2))
    else $error("pickup changed off strobe");
  a_trip_timing: assert property (!$stable(STAGE_TRIP) |-> $past(MEAS_STROBE, 3))
    else $error("trip changed off strobe");
  a_trip_needs_pickup: assert property ($rose(STAGE_TRIP) |-> STAGE_PICKUP)
    else $error("trip without pickup");
  a_block_timing: assert property (
    !$stable({PHASE_INRUSH_BLOCK, COMMON_INRUSH_BLOCK}) |-> $past(MEAS_STROBE))
    else $error("block changed off strobe");
  a_block_mode: assert property (!(|PHASE_INRUSH_BLOCK && COMMON_INRUSH_BLOCK))
    else $error("both block kinds active");
  a_curve_request: assert property (!$stable(CURVE_REQ) |-> $past(MEAS_STROBE))
    else $error("curve request changed off strobe");
  c_trip: cover property ($rose(STAGE_TRIP));
  c_phase: cover property (|PHASE_INRUSH_BLOCK);
  c_common: cover property (COMMON_INRUSH_BLOCK);
  c_err: cover property (PSLVERR);
endmodule
`default_nettype wire

// *** sim/gotb_front_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gotb_front
  import gotb_pkg::*;
#(
  parameter int GAP = 8
) (
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rst,
  // Scenario controls.
  input wire logic [CUR_W-1:0]   i_val,
  input wire logic [1:0]         i_src,
  input wire logic [2:0]         h_mask,
  input wire logic [7:0]         h_pct,
  // Measurement and evaluator pins.
  output logic                   strobe,
  output gotb_ground_type        ground,
  output gotb_harm_type          harm,
  output gotb_dir_type           dir,
  input wire gotb_curve_req_type req,
  output gotb_curve_ans_type     ans
);
  int cnt;
  always_ff @(posedge clk) begin
    cnt <= (rst || cnt == GAP - 1) ? 0 : cnt + 1;
    strobe <= !rst && cnt == GAP - 1;
  end
  // Only the chosen source carries current; its RMS reads half the fundamental.
  always_comb begin
    ground = '0;
    case (i_src)
      2'h0: {ground.computed_fund, ground.computed_rms} = {i_val, i_val >> 1};
      2'h1: {ground.sensed_fund, ground.sensed_rms} = {i_val, i_val >> 1};
      default: {ground.sensitive_fund, ground.sensitive_rms} = {i_val, i_val >> 1};
    endcase
    for (int p = 0; p < 3; p++) begin
      harm.fund[p] = 16'h03e8;
      harm.second[p] = h_mask[p] ? 16'(h_pct * 10) : 16'h0000;
    end
    dir = {4'hf, 4'h0};
  end
  // Curve delay equals the multiplier in ms; delay at largest current is 12 ms.
  assign ans = {20'(req.mult), 20'h00005, 20'h0000c};
endmodule
`default_nettype wire

// *** sim/tb_gotb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_gotb_top
  import gotb_pkg::*;
;
  logic               clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, prdy, perr, e;
  logic               stb, pick, trip, cmn;
  logic [11:0]        pa = '0;
  logic [31:0]        pwd = '0, prd, q;
  logic [2:0]         ph, hm = '0;
  logic [15:0]        iv = '0;
  logic [1:0]         isrc = '0;
  logic [7:0]         hp = '0;
  gotb_ground_type    gm;
  gotb_harm_type      hz;
  gotb_dir_type       dm;
  gotb_curve_req_type req;
  gotb_curve_ans_type ans;
  int                 mismatches = 0, checks = 0;
  always #25 clk = ~clk;
  gotb_top #(.TICK_CYC(4)) dut (
    .CLK_SYS(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .MEAS_STROBE(stb), .GROUND_MEAS(gm), .HARM_MEAS(hz), .DIR_MEAS(dm),
    .CURVE_REQ(req), .CURVE_ANS(ans), .PHASE_INRUSH_BLOCK(ph),
    .COMMON_INRUSH_BLOCK(cmn), .STAGE_PICKUP(pick), .STAGE_TRIP(trip));
  gotb_front #(.GAP(8)) fe (
    .clk(clk), .rst(rst), .i_val(iv), .i_src(isrc), .h_mask(hm), .h_pct(hp),
    .strobe(stb), .ground(gm), .harm(hz), .dir(dm), .req(req), .ans(ans));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    q = prd;
    e = perr;
    if (prdy !== 1'b1) chk(0, 1, "bus timeout");
    {psel, pen} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, 32'h0);
    chk(q, x, m);
  endtask
  // Waits, then compares {phase blocks, common block, trip, pickup}.
  task automatic st(input int n, input logic [5:0] x, input string m);
    repeat (n) @(posedge clk);
    chk({ph, cmn, trip, pick}, x, m);
  endtask
  task automatic results();
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTRL, 32'h0, "ctrl reset");
    rd(ADDR_STATUS, 32'h0, "status reset");
    rd(12'h030, 32'h0, "unmapped data");
    chk(e, 1, "unmapped error");
    wr(12'h040, 32'h64);
    wr(12'h044, 32'h1e);
    wr(12'h054, 32'h200);
    wr(ADDR_CTRL, 32'h48);
    wr(ADDR_RATIO_THR, 32'h0f);
    isrc <= 2'h1;
    iv <= 16'h0096;
    st(80, 6'h01, "fixed early");
    st(64, 6'h03, "fixed trip");
    iv <= 16'h0064;
    st(24, 6'h00, "equal drop");
    rd(ADDR_TIMER, 32'h0, "timer clear");
    wr(12'h054, 32'h300);
    iv <= 16'h0096;
    st(24, 6'h00, "rms");
    wr(12'h054, 32'h200);
    st(24, 6'h01, "fund");
    wr(12'h054, 32'h000);
    st(24, 6'h00, "source");
    wr(12'h054, 32'h200);
    wr(ADDR_CTRL, 32'h49);
    st(24, 6'h01, "forward");
    wr(ADDR_CTRL, 32'h4a);
    st(24, 6'h00, "reverse");
    wr(ADDR_CTRL, 32'h41);
    st(24, 6'h00, "line side");
    wr(ADDR_CTRL, 32'hc8);
    hm <= 3'b010;
    hp <= 8'h14;
    st(24, 6'h10, "per phase");
    wr(ADDR_CTRL, 32'h48);
    st(24, 6'h04, "common");
    hp <= 8'h0f;
    st(24, 6'h01, "ratio equal");
    // Each drop waits for a strobe so that the next delay starts from zero.
    iv <= 16'h0000;
    st(16, 6'h00, "drop before curve");
    wr(12'h048, 32'h4);
    wr(12'h050, 32'h14);
    wr(ADDR_NOMINAL, 32'h4);
    wr(12'h054, 32'h201);
    iv <= 16'h0096;
    st(56, 6'h01, "user min");
    chk(32'(req.imax), 32'h64, "largest current");
    chk(32'(req.mult), 32'h4, "multiplier");
    st(56, 6'h03, "curve trip");
    iv <= 16'h0000;
    st(16, 6'h00, "drop before min off");
    wr(12'h050, 32'h0);
    iv <= 16'h0096;
    st(32, 6'h01, "curve min");
    st(40, 6'h03, "min off");
    iv <= 16'h0000;
    st(16, 6'h00, "drop before log");
    wr(12'h054, 32'h209);
    iv <= 16'h0096;
    st(64, 6'h01, "log min");
    st(48, 6'h03, "log trip");
    wr(12'h04c, 32'h64);
    wr(12'h054, 32'h249);
    iv <= 16'h0000;
    st(24, 6'h00, "slow reset drop");
    iv <= 16'h0096;
    st(16, 6'h03, "slow reset hold");
    // Freeze only once the strobe pipeline has drained.
    @(posedge clk iff stb);
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    iv <= 16'h0000;
    st(24, 6'h03, "enable hold");
    ce <= 1'b1;
    st(16, 6'h00, "enable resume");
    results();
  end
endmodule
bind gotb_top gotb_mon u_mon (.CLK_SYS, .RST, .CE, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .MEAS_STROBE, .CURVE_REQ, .PHASE_INRUSH_BLOCK, .COMMON_INRUSH_BLOCK, .STAGE_PICKUP,
  .STAGE_TRIP);
`default_nettype wire
